// ### dram_ctrl_end.sv
module dram_ctrl_end
  import dram_pd_pkg::*;
(
  input  wire logic              core_clk_i,
  input  wire logic              rst_b_i,
  dram_link_if.ctrl              link,
  input  wire logic              req_valid_i,
  input  cmd_e                   req_cmd_i,
  input  wire logic [BANK_W-1:0] req_bank_i,
  input  wire logic              req_all_i,
  input  wire logic              pd_req_i,
  input  wire logic              sr_req_i,
  input  wire logic              hot_i,
  input  wire logic              slow_exit_i,
  input  wire logic              odt_req_i,
  output logic                   req_ready_o,
  output logic                   asleep_o
);
  // ----------------------------------------
  // Timers
  // ----------------------------------------
  typedef enum logic [2:0] {ST_RUN, ST_PD, ST_SR, ST_XSR, ST_XPD} st_e;
  st_e                  st_r;
  st_e                  st_nxt;
  logic [NUM_BANKS-1:0] open_r;
  logic [REFI_W-1:0]    refi_r;
  logic                 ref_due_r;
  logic [1:0]           hold_r;
  logic [CNT_W-1:0]     rd_wait_r;
  logic                 cke_r;
  cmd_e                 cmd_r;
  logic [BANK_W-1:0]    bank_r;
  logic                 all_r;
  logic                 busy;
  logic                 load;
  logic [CNT_W-1:0]     load_val;

  // Counter runs 0..top inclusive, so top is one below the interval length
  wire  [REFI_W-1:0] refi_top = hot_i ? REFI_W'(REFI_HOT_CYC - 1)
                                      : REFI_W'(REFI_CYC - 1);
  wire  hold_ok   = (hold_r == 2'd0);
  wire  all_idle  = (open_r == '0);
  wire  run_ok    = (st_r == ST_RUN) && !busy;
  wire  do_ref    = run_ok && ref_due_r && all_idle && hold_ok;
  wire  do_sr     = run_ok && !do_ref && sr_req_i && all_idle && hold_ok;
  wire  do_pd     = run_ok && !do_ref && !do_sr && pd_req_i && hold_ok
                  && (rd_wait_r == '0);
  wire  is_read   = req_cmd_i == CMD_READ;
  wire  acc_ok    = req_cmd_i == CMD_ACT || req_cmd_i == CMD_PRE
                  || req_cmd_i == CMD_MRS || open_r[req_bank_i];
  wire  do_req    = run_ok && !do_ref && !do_sr && !do_pd && req_valid_i
                  && acc_ok && !(is_read && rd_wait_r != '0);
  wire  wake      = hold_ok && ((st_r == ST_SR && !sr_req_i)
                  || (st_r == ST_PD && !pd_req_i));

  always_comb begin
    load     = 1'b1;
    load_val = '0;
    if (do_ref) load_val = CNT_W'(RFC_CYC);
    else if (do_req && req_cmd_i == CMD_PRE)
      load_val = req_all_i ? CNT_W'(RPA_CYC) : CNT_W'(RP_CYC);
    else if (wake && st_r == ST_SR) load_val = CNT_W'(XSNR_CYC);
    else if (wake) load_val = CNT_W'(XP_CYC);
    else load = 1'b0;
  end

  wait_counter u_wait (
    .core_clk_i (core_clk_i),
    .rst_b_i    (rst_b_i),
    .load_i     (load),
    .value_i    (load_val),
    .busy_o     (busy)
  );

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      ST_RUN: if (do_sr) st_nxt = ST_SR; else if (do_pd) st_nxt = ST_PD;
      ST_PD:  if (wake) st_nxt = ST_XPD;
      ST_SR:  if (wake) st_nxt = ST_XSR;
      ST_XSR: if (!busy && hold_ok) st_nxt = ST_RUN;
      ST_XPD: if (!busy && hold_ok) st_nxt = ST_RUN;
      default: st_nxt = ST_RUN;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      st_r      <= ST_RUN;
      open_r    <= '0;
      refi_r    <= '0;
      ref_due_r <= 1'b0;
      hold_r    <= 2'd0;
      rd_wait_r <= '0;
      cke_r     <= 1'b1;
      cmd_r     <= CMD_NOP;
      bank_r    <= '0;
      all_r     <= 1'b0;
    end else begin
      st_r   <= st_nxt;
      refi_r <= (refi_r >= refi_top) ? '0 : refi_r + REFI_W'(1);
      // Set wins over clear so a tick during refresh issue is kept
      if (refi_r >= refi_top) ref_due_r <= 1'b1;
      else if (do_ref || do_sr) ref_due_r <= 1'b0;
      if (do_sr || do_pd || wake) hold_r <= 2'(CKE_MIN_CYC - 1);
      else if (hold_r != 2'd0) hold_r <= hold_r - 2'd1;
      if (wake) rd_wait_r <= (st_r == ST_SR) ? CNT_W'(XSRD_CYC)
                            : (slow_exit_i ? CNT_W'(XARDS_CYC) : CNT_W'(XARD_CYC));
      else if (rd_wait_r != '0) rd_wait_r <= rd_wait_r - CNT_W'(1);
      if (do_sr || do_pd) cke_r <= 1'b0;
      else if (wake) cke_r <= 1'b1;
      cmd_r  <= do_ref || do_sr ? CMD_REF : (do_req ? req_cmd_i : CMD_NOP);
      bank_r <= req_bank_i;
      all_r  <= req_all_i;
      if (do_req && req_cmd_i == CMD_ACT) open_r[req_bank_i] <= 1'b1;
      if (do_req && req_cmd_i == CMD_PRE) begin
        if (req_all_i) open_r <= '0;
        else open_r[req_bank_i] <= 1'b0;
      end
    end
  end

  // Termination forced off near self refresh; drops with the request, so entry costs no idle cycle
  assign link.termination_enable = odt_req_i && st_r == ST_RUN && !sr_req_i
                                   && !(st_r == ST_RUN && rd_wait_r != '0);
  assign link.cke             = cke_r;
  assign link.cmd             = cmd_r;
  assign link.bank            = bank_r;
  assign link.all_bank_select = all_r;
  assign link.slow_exit       = slow_exit_i;
  assign req_ready_o          = do_req;
  assign asleep_o             = (st_r == ST_PD) || (st_r == ST_SR);
endmodule // dram_ctrl_end

// ### dram_device_end.sv
module dram_device_end
  import dram_pd_pkg::*;
(
  input  wire logic                 core_clk_i,
  input  wire logic                 rst_b_i,
  dram_link_if.mem                  link,
  output logic [NUM_BANKS-1:0]      bank_open_o,
  output pwr_e                      pwr_state_o,
  output logic                      buffers_on_o,
  output logic                      dll_frozen_o,
  output logic                      refresh_busy_o,
  output logic                      protocol_err_o
);
  // ----------------------------------------
  // Command decode
  // ----------------------------------------
  logic                 cke_prev_r;
  logic [NUM_BANKS-1:0] open_r;
  logic [NUM_BANKS-1:0] open_nxt;
  pwr_e                 pwr_r;
  pwr_e                 pwr_nxt;
  logic [1:0]           cke_hold_r;
  logic                 err_r;
  wire  all_idle   = (open_r == '0);
  wire  is_nop     = (link.cmd == CMD_NOP);
  wire  awake      = (pwr_r == PWR_ON);
  wire  cke_fall   = awake && cke_prev_r && !link.cke;
  wire  cke_rise   = !awake && !cke_prev_r && link.cke;
  wire  sr_enter   = cke_fall && link.cmd == CMD_REF && all_idle;
  wire  pd_enter   = cke_fall && is_nop;
  wire  ref_go     = awake && link.cke && link.cmd == CMD_REF && all_idle;
  wire  cke_change = (link.cke != cke_prev_r);
  wire  bad_cmd    = (cke_fall && !sr_enter && !pd_enter)
                   || (cke_rise && !is_nop)
                   || (cke_change && cke_hold_r != 2'd0)
                   || ((link.cmd == CMD_READ || link.cmd == CMD_WRITE)
                       && awake && link.cke && !open_r[link.bank])
                   || (link.cmd == CMD_REF && awake && !all_idle);

  // ----------------------------------------
  // Bank state
  // ----------------------------------------
  always_comb begin
    open_nxt = open_r;
    if (awake && link.cke) begin
      case (link.cmd)
        CMD_ACT: open_nxt[link.bank] = 1'b1;
        CMD_PRE: begin
          if (link.all_bank_select) open_nxt = '0;
          else open_nxt[link.bank] = 1'b0;
        end
        default: open_nxt = open_r;
      endcase
    end
  end

  always_comb begin
    pwr_nxt = pwr_r;
    case (pwr_r)
      PWR_ON: begin
        if (sr_enter) pwr_nxt = PWR_SR;
        else if (pd_enter) pwr_nxt = all_idle ? PWR_PPD : PWR_APD;
      end
      PWR_PPD, PWR_APD, PWR_SR: begin
        if (cke_rise && is_nop) pwr_nxt = PWR_ON;
      end
      default: pwr_nxt = PWR_ON;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      open_r     <= '0;
      pwr_r      <= PWR_ON;
      cke_prev_r <= 1'b1;
      cke_hold_r <= 2'd0;
      err_r      <= 1'b0;
    end else begin
      open_r     <= open_nxt;
      pwr_r      <= pwr_nxt;
      cke_prev_r <= link.cke;
      cke_hold_r <= cke_change ? 2'(CKE_MIN_CYC - 1) :
                    (cke_hold_r != 2'd0 ? cke_hold_r - 2'd1 : 2'd0);
      err_r      <= bad_cmd;
    end
  end

  wait_counter u_rfc (
    .core_clk_i (core_clk_i),
    .rst_b_i    (rst_b_i),
    .load_i     (ref_go),
    .value_i    (CNT_W'(RFC_CYC)),
    .busy_o     (refresh_busy_o)
  );

  assign bank_open_o    = open_r;
  assign pwr_state_o    = pwr_r;
  assign buffers_on_o   = awake;
  assign dll_frozen_o   = (pwr_r == PWR_PPD) || (pwr_r == PWR_SR);
  assign protocol_err_o = err_r;
endmodule // dram_device_end

// ### dram_link_if.sv
interface dram_link_if;
  import dram_pd_pkg::*;
  logic              cke;
  cmd_e              cmd;
  logic [BANK_W-1:0] bank;
  logic              all_bank_select;
  logic              termination_enable;
  logic              slow_exit;
  modport ctrl (output cke, cmd, bank, all_bank_select, termination_enable, slow_exit);
  modport mem  (input  cke, cmd, bank, all_bank_select, termination_enable, slow_exit);
endinterface

// ### dram_link_props.sv
module dram_link_props
  import dram_pd_pkg::*;
(
  input wire logic              core_clk_i,
  input wire logic              rst_b_i,
  input wire logic              cke,
  input cmd_e                   cmd,
  input wire logic [BANK_W-1:0] bank,
  input wire logic              all_bank_select,
  input wire logic              termination_enable,
  input wire logic              slow_exit
);
  logic                 cke_q_r;
  logic                 in_sr_r;
  logic [7:0]           gap_r;
  logic [NUM_BANKS-1:0] open_r;
  wire sr_in  = cke_q_r & ~cke & (cmd == CMD_REF);
  wire sr_out = ~cke_q_r & cke & in_sr_r;
  wire act    = cke & (cmd == CMD_ACT);
  wire pre    = cke & (cmd == CMD_PRE);
  // --------------------
  // Shadow of link state
  // --------------------
  // Gap counter saturates so long runs never look like a fresh exit
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      cke_q_r <= 1'h1;
      in_sr_r <= 1'h0;
      gap_r   <= 8'hFF;
      open_r  <= '0;
    end else begin
      cke_q_r <= cke;
      in_sr_r <= sr_in | (in_sr_r & ~sr_out);
      gap_r   <= sr_out ? 8'h01 : gap_r + {7'h00, gap_r != 8'hFF};
      if (pre)
        open_r <= all_bank_select ? '0 : open_r & ~(4'h1 << bank);
      else if (act)
        open_r <= open_r | (4'h1 << bank);
    end
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);
  sequence s_sr_exit;
    $rose(cke) && in_sr_r;
  endsequence
  AST_CKE_LOW: assert property ($fell(cke) |-> !cke[*3])
    else $error("cke low held under three edges");
  AST_CKE_HIGH: assert property ($rose(cke) |-> cke[*3])
    else $error("cke high held under three edges");
  AST_ENTRY_CMD: assert property ($fell(cke) |-> cmd inside {CMD_NOP, CMD_REF})
    else $error("sleep entry with wrong command");
  AST_EXIT_CMD: assert property ($rose(cke) |-> cmd == CMD_NOP)
    else $error("wake with wrong command");
  AST_SR_NOP: assert property (s_sr_exit |-> (cmd == CMD_NOP)[*6])
    else $error("command inside self refresh exit gap");
  AST_READ_WAIT: assert property (cmd == CMD_READ |-> gap_r >= 8'hC8)
    else $error("read too soon after self refresh");
  AST_ODT_EXIT: assert property (gap_r < 8'hC8 |-> !termination_enable)
    else $error("termination on after self refresh");
  AST_ODT_ENTRY: assert property (sr_in |-> !termination_enable)
    else $error("termination on at self refresh entry");
  AST_SR_IDLE: assert property (sr_in |-> open_r == '0)
    else $error("self refresh with open bank");
  AST_OPEN_ACC: assert property (cke && cmd inside {CMD_READ, CMD_WRITE} |-> open_r[bank])
    else $error("access to idle bank");
  AST_REF_QUIET: assert property (cke && cmd == CMD_REF |=> (cmd == CMD_NOP)[*5])
    else $error("command inside refresh time");
endmodule // dram_link_props

// ### dram_pd_pkg.sv
// How it works
// - Precharge closes one bank or all
// - Precharged bank needs activate before access
// - Wait precharge time before reusing banks
// - Refresh every 7.8125us average, 64ms
// - Refresh lasts refresh cycle time minimum
// - Above 85C refresh every 3.9us
// - Refresh with clock enable low enters self refresh
// - Only nop after self refresh exit
// - Exit intervals count from first registered high
// - Reads wait 200 cycles after self refresh
// - Clock enable stays high until read time; power-down entry waits for it, self refresh entry does not
// - Termination off around self refresh
// - Self refresh only with all banks idle
// - Clock enable high through bursts; the code may start power-down and drop it the cycle after a read or write
// - Clock enable low with nop enters power-down
// - Idle banks give precharge power-down, else active
// - Power-down disables buffers, freezes loop if precharge
// - Clock enable high with nop exits power-down
// - Clock enable levels held three edges
// - Power-down exit read and nonread waits
// - No column access at power-down entry
package dram_pd_pkg;
  localparam int unsigned CLK_PERIOD_PS   = 25000;
  localparam int unsigned NUM_BANKS       = 4;
  localparam int unsigned BANK_W          = 2;
  // Times in ps, refresh intervals in ns
  localparam int unsigned T_RP_PS         = 15000;
  localparam int unsigned T_RPA_PS        = 17500;
  localparam int unsigned T_RFC_PS        = 127500;
  localparam int unsigned T_XSNR_PS       = 137500;
  localparam int unsigned T_REFI_NS       = 7812;
  localparam int unsigned T_REFI_HOT_NS   = 3900;
  localparam int unsigned RP_CYC   = (T_RP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned RPA_CYC  = (T_RPA_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned RFC_CYC  = (T_RFC_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned XSNR_CYC = (T_XSNR_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned XSRD_CYC = 200;
  localparam int unsigned XP_CYC   = 2;
  localparam int unsigned XARD_CYC = 2;
  localparam int unsigned XARDS_CYC = 7;
  localparam int unsigned CKE_MIN_CYC = 3;
  localparam int unsigned REFI_CYC     = (T_REFI_NS * 1000) / CLK_PERIOD_PS;
  localparam int unsigned REFI_HOT_CYC = (T_REFI_HOT_NS * 1000) / CLK_PERIOD_PS;
  localparam int unsigned CNT_W    = 9;
  localparam int unsigned REFI_W   = 9;
  localparam int unsigned SLOW_EXIT_BIT = 12;

  typedef enum logic [2:0] {
    CMD_NOP, CMD_ACT, CMD_READ, CMD_WRITE, CMD_PRE, CMD_REF, CMD_MRS
  } cmd_e;

  typedef enum logic [1:0] {
    PWR_ON, PWR_PPD, PWR_APD, PWR_SR
  } pwr_e;
endpackage

// ### tb_top.sv
`define CHK(nm, e, g) samples_checked++; if ((g) !== (e)) begin n_mismatch++; \
  $display("Error %s expected %0h seen %0h", nm, e, g); end
module tb_top
  import dram_pd_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {cmd_e c; logic [1:0] b; logic a; logic [3:0] o;} row_s;
  logic core_clk_i = 1'h0, rst_b_i, req_valid_i, req_all_i, pd_req_i, sr_req_i;
  logic hot_i, slow_exit_i, odt_req_i, req_ready_o, asleep_o, buffers_on_o;
  logic dll_frozen_o, refresh_busy_o, protocol_err_o, err_seen = 1'h0;
  cmd_e req_cmd_i;
  pwr_e pwr_state_o;
  logic [1:0] req_bank_i;
  logic [3:0] bank_open_o;
  int n_mismatch = 0, samples_checked = 0, k, n;
  row_s rows[9] = '{'{CMD_ACT, 2'h0, 1'h0, 4'h1}, '{CMD_ACT, 2'h2, 1'h0, 4'h5},
    '{CMD_PRE, 2'h0, 1'h0, 4'h4}, '{CMD_ACT, 2'h1, 1'h0, 4'h6}, '{CMD_PRE, 2'h0, 1'h1, 4'h0},
    '{CMD_ACT, 2'h3, 1'h0, 4'h8}, '{CMD_WRITE, 2'h3, 1'h0, 4'h8},
    '{CMD_READ, 2'h3, 1'h0, 4'h8}, '{CMD_PRE, 2'h3, 1'h0, 4'h0}};
  dram_link_if link ();
  dram_ctrl_end i_dram_ctrl_end (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .link(link),
    .req_valid_i(req_valid_i), .req_cmd_i(req_cmd_i), .req_bank_i(req_bank_i),
    .req_all_i(req_all_i), .pd_req_i(pd_req_i), .sr_req_i(sr_req_i), .hot_i(hot_i),
    .slow_exit_i(slow_exit_i), .odt_req_i(odt_req_i), .req_ready_o(req_ready_o),
    .asleep_o(asleep_o));
  dram_device_end i_dram_device_end (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
    .link(link), .bank_open_o(bank_open_o), .pwr_state_o(pwr_state_o),
    .buffers_on_o(buffers_on_o), .dll_frozen_o(dll_frozen_o),
    .refresh_busy_o(refresh_busy_o), .protocol_err_o(protocol_err_o));
  dram_link_props i_dram_link_props (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
    .cke(link.cke), .cmd(link.cmd), .bank(link.bank), .all_bank_select(link.all_bank_select),
    .termination_enable(link.termination_enable), .slow_exit(link.slow_exit));
  always #12.5 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) if (protocol_err_o === 1'h1) err_seen <= 1'h1;
  // ---------------
  // Shared tasks
  // ---------------
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic give_up(input string what);
    $display("Error %s expected event seen timeout", what);
    n_mismatch++;
    tally_and_finish();
  endtask
  // Request held until the edge where ready is seen high
  task automatic issue(input cmd_e c, input logic [1:0] b, input logic a);
    int i;
    @(posedge core_clk_i);
    req_valid_i <= 1'h1;
    req_cmd_i <= c;
    req_bank_i <= b;
    req_all_i <= a;
    for (i = 0; i < 400 && req_ready_o !== 1'h1; i++) @(negedge core_clk_i);
    if (i == 400) give_up("req_ready_o");
    @(posedge core_clk_i);
    req_valid_i <= 1'h0;
  endtask
  task automatic wait_pwr(input pwr_e p);
    int i;
    for (i = 0; i < 40 && pwr_state_o !== p; i++) @(negedge core_clk_i);
    if (i == 40) give_up("pwr_state_o");
  endtask
  task automatic wait_busy();
    int i;
    for (i = 0; i < 400 && refresh_busy_o !== 1'h1; i++) @(negedge core_clk_i);
    if (i == 400) give_up("refresh_busy_o");
  endtask
  initial begin
    {rst_b_i, req_valid_i, req_all_i, pd_req_i, sr_req_i, hot_i} = '0;
    {slow_exit_i, odt_req_i, req_bank_i} = '0;
    req_cmd_i = CMD_NOP;
    repeat (16) @(negedge core_clk_i);
    `CHK("bank_open_o", 4'h0, bank_open_o)
    `CHK("pwr_state_o", PWR_ON, pwr_state_o)
    `CHK("link.cke", 1'h1, link.cke)
    @(posedge core_clk_i);
    rst_b_i <= 1'h1;
    $display("test reset done");
    for (k = 0; k < 9; k++) begin
      issue(rows[k].c, rows[k].b, rows[k].a);
      repeat (2) @(negedge core_clk_i);
      `CHK("bank_open_o", rows[k].o, bank_open_o)
    end
    $display("test table done");
    @(posedge core_clk_i);
    req_valid_i <= 1'h1;
    req_cmd_i <= CMD_READ;
    req_bank_i <= 2'h0;
    n = 0;
    repeat (20) @(negedge core_clk_i) n += (req_ready_o === 1'h1);
    `CHK("refused read", 0, n)
    @(posedge core_clk_i);
    req_valid_i <= 1'h0;
    $display("test refuse done");
    issue(CMD_ACT, 2'h1, 1'h0);
    pd_req_i <= 1'h1;
    wait_pwr(PWR_APD);
    `CHK("buffers_on_o", 1'h0, buffers_on_o)
    `CHK("dll_frozen_o", 1'h0, dll_frozen_o)
    `CHK("asleep_o", 1'h1, asleep_o)
    @(posedge core_clk_i);
    pd_req_i <= 1'h0;
    wait_pwr(PWR_ON);
    `CHK("bank_open_o", 4'h2, bank_open_o)
    issue(CMD_PRE, 2'h0, 1'h1);
    slow_exit_i <= 1'h1;
    pd_req_i <= 1'h1;
    wait_pwr(PWR_PPD);
    `CHK("dll_frozen_o", 1'h1, dll_frozen_o)
    @(posedge core_clk_i);
    pd_req_i <= 1'h0;
    wait_pwr(PWR_ON);
    $display("test power-down done");
    odt_req_i <= 1'h1;
    sr_req_i <= 1'h1;
    wait_pwr(PWR_SR);
    `CHK("link.cke", 1'h0, link.cke)
    `CHK("termination", 1'h0, link.termination_enable)
    repeat (5) @(posedge core_clk_i);
    sr_req_i <= 1'h0;
    wait_pwr(PWR_ON);
    issue(CMD_ACT, 2'h0, 1'h0);
    issue(CMD_READ, 2'h0, 1'h0);
    issue(CMD_PRE, 2'h0, 1'h1);
    odt_req_i <= 1'h0;
    $display("test self refresh done");
    hot_i <= 1'h1;
    wait_busy();
    for (n = 0; n < 400 && refresh_busy_o === 1'h1; n++) @(negedge core_clk_i);
    `CHK("refresh length", RFC_CYC, n)
    wait_busy();
    wait_busy();
    for (k = n; k < 400 && refresh_busy_o === 1'h1; k++) @(negedge core_clk_i);
    for (n = k - n; n < 400 && refresh_busy_o !== 1'h1; n++) @(negedge core_clk_i);
    `CHK("hot interval ok", 1'h1, n <= REFI_HOT_CYC)
    `CHK("protocol_err_o", 1'h0, err_seen)
    $display("test refresh done");
    tally_and_finish();
  end
endmodule // tb_top

// ### wait_counter.sv
module wait_counter
  import dram_pd_pkg::*;
(
  input  wire logic             core_clk_i,
  input  wire logic             rst_b_i,
  input  wire logic             load_i,
  input  wire logic [CNT_W-1:0] value_i,
  output logic                  busy_o
);
  logic [CNT_W-1:0] cnt_r;
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) cnt_r <= '0;
    else if (load_i) cnt_r <= value_i;
    else if (cnt_r != '0) cnt_r <= cnt_r - CNT_W'(1);
  end
  // Load is left out so a user may gate its own load on busy without a loop
  assign busy_o = (cnt_r != '0);
endmodule // wait_counter
